// file: core/fault_auto_retry_ctrl.sv
// Fault auto-retry supervisor with cooling-fan failure handling and AXI4-Lite registers.
`timescale 1ns/100ps
`default_nettype none

module fault_auto_retry_ctrl
	import fault_retry_pkg::*;
#(
	parameter longint CLEAN_RUN_CYCLES  = CLEAN_RUN_CYC,
	parameter longint FAN_PERIOD_CYCLES = FAN_PERIOD_CYC,
	parameter longint FAN_OFF_CYCLES    = FAN_OFF_CYC,
	parameter longint RETRY_CYCLES      = RETRY_CYC,
	parameter int     CNT_W             = 33
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// AXI4-Lite write address, data and response
	input  wire logic [15:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read
	input  wire logic [15:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Drive status and fault detectors
	input  wire logic                 run_cmd,
	input  wire logic [FAULT_W-1:0]   fault_in,
	input  wire logic                 self_check_ok,
	input  wire logic                 baseblock_done,
	input  wire logic                 fan_failure,
	input  wire logic                 ext_fault_reset,
	// Actions toward the power stage
	output logic                      fault_reset_pulse,
	output logic                      speed_search_start,
	output logic                      coast_stop,
	output logic                      trip_active,
	output logic                      overtemp_major,
	output logic                      minor_fault,
	output logic                      minor_blink,
	output logic [7:0]                rated_current_pct,
	output logic [7:0]                overload_pct_a,
	output logic [15:0]               overload_sec_a,
	output logic [7:0]                overload_pct_b,
	output logic [15:0]               overload_sec_b,
	output logic                      fan_run,
	// Contact outputs
	output logic                      fault_contact,
	output logic                      function_contact,
	output logic                      restart_enabled
);

	typedef struct packed {
		retry_state_t     st;
		logic [15:0]      limit;
		logic             contact_sel;
		logic             severity;
		logic [7:0]       func_sel;
		logic [1:0]       ride_sel;
		logic             vt_duty;
		logic [3:0]       count;
		logic [CNT_W-1:0] timer;
		logic [CNT_W-1:0] clean_tmr;
		logic             clean_arm;
		logic [CNT_W-1:0] fan_tmr;
		logic [23:0]      blink_tmr;
		logic             blink;
		logic             pulse;
		logic             search;
		logic             aw_got;
		logic             w_got;
		logic [15:0]      aw_addr;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic             bad_w;
		logic             rvalid;
		logic [31:0]      rdata;
		logic             bad_r;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Maps a byte address to a register index; misaligned gives all ones.
	function automatic logic [11:0] reg_index(input logic [15:0] a);
		reg_index = (a[1:0] == 2'b00) ? a[13:2] : 12'hFFF;
	endfunction

	// True while the restart count has not yet used up the configured limit.
	// A limit of zero therefore never allows a restart.
	function automatic logic below_limit(input logic [3:0] c, input logic [15:0] lim);
		below_limit = ({12'h0, c} < lim);
	endfunction

	// Only the mapped indices answer OKAY; the rest answer SLVERR.
	function automatic logic known_reg(input logic [11:0] i);
		known_reg = (i == RESTART_LIMIT_IDX) || (i == RETRY_CONTACT_IDX) ||
			(i == COOLER_SEVERITY_IDX) || (i == CONTACT_FUNC_IDX) ||
			(i == RIDE_THROUGH_IDX) || (i == DUTY_SELECT_IDX) || (i == STATUS_IDX);
	endfunction

	logic [FAULT_W-1:0] eligible_mask;
	logic               any_fault;
	logic               eligible_fault;
	logic               fan_major;
	logic               fan_minor;
	logic               retrying;

	always_comb begin
		eligible_mask = '1;
		eligible_mask[F_OTHER] = 1'b0;
		eligible_mask[F_LINK_LOW] = (s_q.ride_sel == 2'd1) || (s_q.ride_sel == 2'd2);
		fan_major = fan_failure && s_q.severity;
		fan_minor = fan_failure && !s_q.severity;
		any_fault = (|fault_in) || fan_major;
		eligible_fault = (|(fault_in & eligible_mask)) && !fault_in[F_OTHER];
		retrying = (s_q.st == ST_BASEBLOCK) || (s_q.st == ST_RETRY) || (s_q.st == ST_SEARCH);
	end

	logic [11:0] widx;
	logic [11:0] ridx;
	logic [15:0] wlo;

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		s_d.search = 1'b0;
		widx = reg_index(s_q.aw_addr);
		ridx = reg_index(s_axi_araddr);
		wlo = s_q.limit;

		// Bus write: collect address and data in either order.
		// Both channels are refused while a response is still waiting, which
		// keeps the single write slot simple at the cost of one idle cycle.
		if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bad_w = !known_reg(widx);
			if (s_q.w_strb[1:0] == 2'b11) begin
				wlo = s_q.w_data[15:0];
				case (widx)
					RESTART_LIMIT_IDX: begin
						if (wlo <= RESTART_LIMIT_MAX)
							s_d.limit = wlo;
					end
					RETRY_CONTACT_IDX:   s_d.contact_sel = wlo[0];
					COOLER_SEVERITY_IDX: s_d.severity = wlo[0];
					CONTACT_FUNC_IDX:    s_d.func_sel = wlo[7:0];
					RIDE_THROUGH_IDX:    s_d.ride_sel = wlo[1:0];
					DUTY_SELECT_IDX:     s_d.vt_duty = wlo[0];
					default: ;
				endcase
			end
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// Bus read.
		// The address is decoded straight from the bus, so the data reflects
		// the state at the edge that takes the request.
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.bad_r = !known_reg(ridx);
			case (ridx)
				RESTART_LIMIT_IDX:   s_d.rdata = {16'h0000, s_q.limit};
				RETRY_CONTACT_IDX:   s_d.rdata = {31'h0, s_q.contact_sel};
				COOLER_SEVERITY_IDX: s_d.rdata = {31'h0, s_q.severity};
				CONTACT_FUNC_IDX:    s_d.rdata = {24'h0, s_q.func_sel};
				RIDE_THROUGH_IDX:    s_d.rdata = {30'h0, s_q.ride_sel};
				DUTY_SELECT_IDX:     s_d.rdata = {31'h0, s_q.vt_duty};
				STATUS_IDX:          s_d.rdata = {21'h0, fan_minor, retrying,
					s_q.st == ST_TRIP, s_q.count, 1'b0, s_q.st};
				default:             s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;

		// Retry sequencer.
		// A new fault is only taken up in ST_RUN while the motor is commanded to run;
		// a fault seen while stopped does not start a retry cycle.
		case (s_q.st)
			ST_RUN: begin
				if (s_q.clean_arm) begin
					if (s_q.clean_tmr >= CNT_W'(CLEAN_RUN_CYCLES - 1)) begin
						s_d.count = 4'd0;
						s_d.clean_arm = 1'b0;
					end else begin
						s_d.clean_tmr = s_q.clean_tmr + 1'b1;
					end
				end
				if (run_cmd && any_fault) begin
					s_d.clean_arm = 1'b0;
					s_d.timer = '0;
					if (eligible_fault && !fan_major && below_limit(s_q.count, s_q.limit))
						s_d.st = ST_BASEBLOCK;
					else
						s_d.st = ST_TRIP;
				end
			end
			ST_BASEBLOCK: begin
				if (baseblock_done) begin
					s_d.st = ST_RETRY;
					s_d.timer = '0;
				end
			end
			ST_RETRY: begin
				// paced reset attempts
				// A failed self-check keeps the drive here; the limit is only
				// checked again once a restart has resumed running.
				if (s_q.timer >= CNT_W'(RETRY_CYCLES - 1)) begin
					s_d.timer = '0;
					s_d.pulse = 1'b1;
					if (self_check_ok && !any_fault) begin
						s_d.search = 1'b1;
						s_d.st = ST_SEARCH;
					end
				end else begin
					s_d.timer = s_q.timer + 1'b1;
				end
			end
			ST_SEARCH: begin
				s_d.count = s_q.count + 4'd1;
				s_d.clean_tmr = '0;
				s_d.clean_arm = 1'b1;
				s_d.st = ST_RUN;
			end
			ST_TRIP: begin
				if (ext_fault_reset) begin
					s_d.count = 4'd0;
					s_d.clean_arm = 1'b0;
					s_d.st = ST_RUN;
				end
			end
			default: s_d.st = ST_RUN;
		endcase

		// fan interval running
		// The phase restarts with each new failure, so the off window always
		// opens the cycle.
		if (fan_failure) begin
			if (s_q.fan_tmr >= CNT_W'(FAN_PERIOD_CYCLES - 1))
				s_d.fan_tmr = '0;
			else
				s_d.fan_tmr = s_q.fan_tmr + 1'b1;
		end else begin
			s_d.fan_tmr = '0;
		end

		if (s_q.blink_tmr >= 24'(CLK_HZ / 2 - 1)) begin
			s_d.blink_tmr = 24'h0;
			s_d.blink = !s_q.blink;
		end else begin
			s_d.blink_tmr = s_q.blink_tmr + 24'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.st <= ST_RUN;
			s_q.limit <= RESTART_LIMIT_RST;
			s_q.contact_sel <= RETRY_CONTACT_RST[0];
			s_q.severity <= COOLER_SEVERITY_RST[0];
			s_q.func_sel <= CONTACT_FUNC_RST[7:0];
			s_q.ride_sel <= RIDE_THROUGH_RST[1:0];
			s_q.vt_duty <= DUTY_SELECT_RST[0];
		end else begin
			s_q <= s_d;
		end
	end

	// Write channels are held ready only while the slot is free, so a late
	// response never overlaps a new write.
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bad_w ? 2'b10 : 2'b00;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.bad_r ? 2'b10 : 2'b00;

	assign fault_reset_pulse  = s_q.pulse;
	assign speed_search_start = s_q.search;
	assign trip_active        = s_q.st == ST_TRIP;
	assign coast_stop         = trip_active || retrying;
	assign overtemp_major     = fan_major;
	assign minor_fault        = fan_minor;
	assign minor_blink        = fan_minor && s_q.blink;
	assign rated_current_pct  = fan_minor ? RATED_PCT_DERATED : RATED_PCT_NORMAL;
	assign overload_pct_a     = s_q.vt_duty ? VT_OL_PCT_A : CT_OL_PCT_A;
	assign overload_sec_a     = s_q.vt_duty ? VT_OL_SEC_A : CT_OL_SEC_A;
	assign overload_pct_b     = s_q.vt_duty ? VT_OL_PCT_B : CT_OL_PCT_B;
	assign overload_sec_b     = s_q.vt_duty ? VT_OL_SEC_B : CT_OL_SEC_B;
	assign fan_run = !(fan_failure && (s_q.fan_tmr < CNT_W'(FAN_OFF_CYCLES)));
	assign fault_contact = trip_active || (retrying && s_q.contact_sel);
	assign restart_enabled = (s_q.st == ST_RUN) && below_limit(s_q.count, s_q.limit);
	assign function_contact =
		(s_q.func_sel == FUNC_RESTART_EN) ? restart_enabled :
		((s_q.func_sel == FUNC_MINOR_FAULT) || (s_q.func_sel == FUNC_COOLER_FAIL)) ? fan_minor :
		1'b0;

endmodule

`default_nettype wire

// file: core/fault_retry_pkg.sv
// Package of constants and types for the fault auto-retry supervisor.
package fault_retry_pkg;

	// Register indices as printed; byte address is four times the index.
	localparam logic [11:0] RESTART_LIMIT_IDX   = 12'h49E;
	localparam logic [11:0] RETRY_CONTACT_IDX   = 12'h49F;
	localparam logic [11:0] COOLER_SEVERITY_IDX = 12'h4E2;
	localparam logic [11:0] CONTACT_FUNC_IDX    = 12'h500;
	localparam logic [11:0] RIDE_THROUGH_IDX    = 12'h501;
	localparam logic [11:0] DUTY_SELECT_IDX     = 12'h502;
	localparam logic [11:0] STATUS_IDX          = 12'h503;

	// Reset values.
	localparam logic [15:0] RESTART_LIMIT_RST   = 16'h0000;
	localparam logic [15:0] RETRY_CONTACT_RST   = 16'h0000;
	localparam logic [15:0] COOLER_SEVERITY_RST = 16'h0001;
	localparam logic [15:0] CONTACT_FUNC_RST    = 16'h0000;
	localparam logic [15:0] RIDE_THROUGH_RST    = 16'h0000;
	localparam logic [15:0] DUTY_SELECT_RST     = 16'h0000;

	// Limits and codes.
	localparam logic [15:0] RESTART_LIMIT_MAX   = 16'h000A;
	localparam logic [7:0]  FUNC_RESTART_EN     = 8'h1E;
	localparam logic [7:0]  FUNC_MINOR_FAULT    = 8'h10;
	localparam logic [7:0]  FUNC_COOLER_FAIL    = 8'h3D;

	// Derating figures in percent and overload times in seconds.
	localparam logic [7:0]  RATED_PCT_NORMAL    = 8'h64;
	localparam logic [7:0]  RATED_PCT_DERATED   = 8'h50;
	localparam logic [7:0]  CT_OL_PCT_A         = 8'h64;
	localparam logic [7:0]  CT_OL_PCT_B         = 8'h96;
	localparam logic [7:0]  VT_OL_PCT_A         = 8'h64;
	localparam logic [7:0]  VT_OL_PCT_B         = 8'h78;
	localparam logic [15:0] CT_OL_SEC_A         = 16'h00B4;
	localparam logic [15:0] CT_OL_SEC_B         = 16'h000F;
	localparam logic [15:0] VT_OL_SEC_A         = 16'h001E;
	localparam logic [15:0] VT_OL_SEC_B         = 16'h000A;

	// Timing, in the unit named, and the clock rate.
	localparam longint CLK_HZ         = 10000000;
	localparam longint RETRY_PERIOD_US = 5000;
	localparam longint CLEAN_RUN_MIN  = 10;
	localparam longint FAN_PERIOD_S   = 60;
	localparam longint FAN_OFF_S      = 3;
	localparam longint RETRY_CYC      = RETRY_PERIOD_US * CLK_HZ / 1000000;
	localparam longint CLEAN_RUN_CYC  = CLEAN_RUN_MIN * 60 * CLK_HZ;
	localparam longint FAN_PERIOD_CYC = FAN_PERIOD_S * CLK_HZ;
	localparam longint FAN_OFF_CYC    = FAN_OFF_S * CLK_HZ;

	// Fault input bit positions.
	localparam int F_EXCESS_CURRENT = 0;
	localparam int F_EARTH_LEAK     = 1;
	localparam int F_BLOWN_FUSE     = 2;
	localparam int F_LINK_HIGH      = 3;
	localparam int F_LINK_LOW       = 4;
	localparam int F_SUPPLY_PHASE   = 5;
	localparam int F_OUTPUT_PHASE   = 6;
	localparam int F_BRAKE_RES_HOT  = 7;
	localparam int F_BRAKE_SWITCH   = 8;
	localparam int F_MOTOR_LOAD     = 9;
	localparam int F_DRIVE_LOAD     = 10;
	localparam int F_OVERTEMP       = 11;
	localparam int F_TORQUE_A       = 12;
	localparam int F_TORQUE_B       = 13;
	localparam int F_OTHER          = 14;
	localparam int FAULT_W          = 15;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_BASEBLOCK,
		ST_RETRY,
		ST_SEARCH,
		ST_TRIP
	} retry_state_t;

endpackage

// file: test/fault_retry_assertions.sv
// Concurrent checks on the fault auto-retry supervisor ports.
`timescale 1ns/100ps
`default_nettype none
module fault_retry_assertions
	import fault_retry_pkg::*;
#(
	parameter longint FAN_OFF_CYCLES = FAN_OFF_CYC
) (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_b,
	// Bus response
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	// Supervisor outputs
	input wire logic       fault_reset_pulse,
	input wire logic       speed_search_start,
	input wire logic       coast_stop,
	input wire logic       trip_active,
	input wire logic       overtemp_major,
	input wire logic       minor_fault,
	input wire logic [7:0] rated_current_pct,
	input wire logic       fan_run
);
	logic [15:0] off_q;
	logic [15:0] off_d;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	always_comb off_d = fan_run ? 16'h0000 : off_q + 16'h0001;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			off_q <= 16'h0000;
		else
			off_q <= off_d;
	end
	sequence s_retry_miss;
		fault_reset_pulse && !speed_search_start;
	endsequence
	property p_pace;
		s_retry_miss |-> ##20 fault_reset_pulse;
	endproperty
	chk_pulse_single: assert property (fault_reset_pulse |=> !fault_reset_pulse)
		else $error("fault reset pulse longer than one cycle");
	chk_retry_pace: assert property (p_pace)
		else $error("fault reset attempts not paced");
	chk_search_paired: assert property (speed_search_start |-> fault_reset_pulse)
		else $error("restart without a reset attempt");
	chk_trip_quiet: assert property (trip_active |-> !fault_reset_pulse && coast_stop)
		else $error("retry activity during trip");
	chk_major_trip: assert property (overtemp_major |-> ##[0:3] trip_active)
		else $error("major fan failure did not trip");
	chk_minor_runs: assert property (minor_fault |-> !overtemp_major && !trip_active)
		else $error("minor fan failure stopped the drive");
	chk_minor_derate: assert property (minor_fault && $past(minor_fault)
		|-> rated_current_pct == RATED_PCT_DERATED)
		else $error("rated current not derated");
	chk_fan_off_bound: assert property (off_q <= 16'(FAN_OFF_CYCLES))
		else $error("fan off too long");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule
bind fault_auto_retry_ctrl fault_retry_assertions #(.FAN_OFF_CYCLES(FAN_OFF_CYCLES)) i_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .fault_reset_pulse(fault_reset_pulse),
	.speed_search_start(speed_search_start), .coast_stop(coast_stop),
	.trip_active(trip_active), .overtemp_major(overtemp_major), .minor_fault(minor_fault),
	.rated_current_pct(rated_current_pct), .fan_run(fan_run));
`default_nettype wire

// file: test/power_stage_model.sv
// Model of the power stage and self-check facing the supervisor.
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
	import fault_retry_pkg::*;
#(
	parameter int BB_CYCLES = 5
) (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	// From the supervisor and the detectors
	input  wire logic               coast_stop,
	input  wire logic [FAULT_W-1:0] fault_in,
	// Back to the supervisor
	output logic                    baseblock_done,
	output logic                    self_check_ok
);
	int bb_cnt;
	// Baseblock is only over once the output has stayed off for a while.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			bb_cnt <= 0;
		else if (!coast_stop)
			bb_cnt <= 0;
		else if (bb_cnt < BB_CYCLES)
			bb_cnt <= bb_cnt + 1;
	end
	assign baseblock_done = coast_stop && (bb_cnt == BB_CYCLES);
	assign self_check_ok  = (fault_in == '0);
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the fault auto-retry supervisor.
`timescale 1ns/100ps
`default_nettype none
module testbench import fault_retry_pkg::*;;
	logic               sys_clk, rst_b, run_cmd, self_check_ok, baseblock_done, fan_failure;
	logic               ext_fault_reset, fault_reset_pulse, speed_search_start, coast_stop;
	logic               trip_active, overtemp_major, minor_fault, minor_blink, fan_run;
	logic               fault_contact, function_contact, restart_enabled;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic [3:0]         s_axi_wstrb;
	logic [7:0]         rated_current_pct, overload_pct_a, overload_pct_b;
	logic [15:0]        s_axi_awaddr, s_axi_araddr, overload_sec_a, overload_sec_b;
	logic [31:0]        s_axi_wdata, s_axi_rdata, d;
	logic [1:0]         r;
	logic [FAULT_W-1:0] fault_in;
	logic               ok;
	int                 mismatches, n_checks;

	fault_auto_retry_ctrl #(.CLEAN_RUN_CYCLES(200), .FAN_PERIOD_CYCLES(200),
		.FAN_OFF_CYCLES(10), .RETRY_CYCLES(20)) i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .run_cmd(run_cmd), .fault_in(fault_in),
		.self_check_ok(self_check_ok), .baseblock_done(baseblock_done),
		.fan_failure(fan_failure), .ext_fault_reset(ext_fault_reset),
		.fault_reset_pulse(fault_reset_pulse), .speed_search_start(speed_search_start),
		.coast_stop(coast_stop), .trip_active(trip_active), .overtemp_major(overtemp_major),
		.minor_fault(minor_fault), .minor_blink(minor_blink),
		.rated_current_pct(rated_current_pct), .overload_pct_a(overload_pct_a),
		.overload_sec_a(overload_sec_a), .overload_pct_b(overload_pct_b),
		.overload_sec_b(overload_sec_b), .fan_run(fan_run), .fault_contact(fault_contact),
		.function_contact(function_contact), .restart_enabled(restart_enabled));
	power_stage_model i_stage (.sys_clk(sys_clk), .rst_b(rst_b), .coast_stop(coast_stop),
		.fault_in(fault_in), .baseblock_done(baseblock_done), .self_check_ok(self_check_ok));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chb(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [11:0] idx, input logic [31:0] v);
		logic aw = 1'b0;
		logic w = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] idx);
		@(posedge sys_clk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic hit(input int b);
		fault_in <= FAULT_W'(1) << b;
		@(posedge sys_clk);
		fault_in <= '0;
	endtask
	task automatic srch();
		ok = 1'b0;
		for (int n = 0; n < 300 && ok !== 1'b1; n++) begin
			@(posedge sys_clk);
			ok = speed_search_start;
		end
	endtask
	// An external reset only acts once the drive has tripped.
	task automatic clr();
		ext_fault_reset <= 1'b1;
		cyc(2);
		ext_fault_reset <= 1'b0;
		cyc(2);
	endtask
	task automatic t_regs();
		rd(RESTART_LIMIT_IDX);
		chk(d, 32'h0);
		rd(RETRY_CONTACT_IDX);
		chk(d, 32'h0);
		rd(COOLER_SEVERITY_IDX);
		chk(d, 32'h1);
		rd(12'h7FF);
		chk({30'h0, r}, 32'h2);
		wr(12'h7FF, 32'h0);
		chk({30'h0, r}, 32'h2);
		wr(RESTART_LIMIT_IDX, 32'hA);
		chk({30'h0, r}, 32'h0);
		wr(RESTART_LIMIT_IDX, 32'hB);
		rd(RESTART_LIMIT_IDX);
		chk(d, 32'hA);
	endtask
	// Every eligible kind restarts; the clean run clears the count each time.
	task automatic t_elig();
		wr(RIDE_THROUGH_IDX, 32'h1);
		for (int b = 0; b < 14; b++) begin
			hit(b);
			srch();
			chb(ok, 1'b1);
			cyc(2);
			rd(STATUS_IDX);
			chk({28'h0, d[7:4]}, 32'h1);
			cyc(205);
			rd(STATUS_IDX);
			chk({28'h0, d[7:4]}, 32'h0);
		end
		hit(14);
		cyc(3);
		chb(trip_active, 1'b1);
		clr();
	endtask
	task automatic t_limit();
		wr(RESTART_LIMIT_IDX, 32'h1);
		wr(RETRY_CONTACT_IDX, 32'h1);
		wr(CONTACT_FUNC_IDX, {24'h0, FUNC_RESTART_EN});
		cyc(2);
		chb(function_contact, 1'b1);
		chb(restart_enabled, 1'b1);
		fault_in <= FAULT_W'(1);
		cyc(60);
		chb(fault_contact, 1'b1);
		rd(STATUS_IDX);
		chk({29'h0, d[2:0]}, 32'h2);
		wr(RETRY_CONTACT_IDX, 32'h0);
		cyc(2);
		chb(fault_contact, 1'b0);
		fault_in <= '0;
		srch();
		chb(ok, 1'b1);
		cyc(2);
		hit(0);
		cyc(3);
		chb(trip_active, 1'b1);
		chb(restart_enabled, 1'b0);
		clr();
		rd(STATUS_IDX);
		chk({24'h0, d[7:0]}, 32'h0);
		wr(RIDE_THROUGH_IDX, 32'h0);
		hit(F_LINK_LOW);
		cyc(3);
		chb(trip_active, 1'b1);
		clr();
		wr(RESTART_LIMIT_IDX, 32'h0);
		hit(0);
		cyc(3);
		chb(trip_active, 1'b1);
		clr();
	endtask
	task automatic t_fan();
		int n = 0;
		wr(COOLER_SEVERITY_IDX, 32'h0);
		wr(CONTACT_FUNC_IDX, {24'h0, FUNC_MINOR_FAULT});
		fan_failure <= 1'b1;
		cyc(3);
		chb(minor_fault, 1'b1);
		chb(trip_active, 1'b0);
		chb(function_contact, 1'b1);
		chk({24'h0, rated_current_pct}, {24'h0, RATED_PCT_DERATED});
		chk({overload_pct_a, overload_sec_a, overload_pct_b},
			{CT_OL_PCT_A, CT_OL_SEC_A, CT_OL_PCT_B});
		chk({16'h0, overload_sec_b}, {16'h0, CT_OL_SEC_B});
		wr(DUTY_SELECT_IDX, 32'h1);
		cyc(2);
		chk({overload_pct_a, overload_sec_a, overload_pct_b},
			{VT_OL_PCT_A, VT_OL_SEC_A, VT_OL_PCT_B});
		chk({16'h0, overload_sec_b}, {16'h0, VT_OL_SEC_B});
		repeat (200) begin
			@(posedge sys_clk);
			if (fan_run === 1'b0)
				n++;
		end
		chk(n, 32'd10);
		fan_failure <= 1'b0;
		wr(COOLER_SEVERITY_IDX, 32'h1);
		fan_failure <= 1'b1;
		cyc(4);
		chb(overtemp_major, 1'b1);
		chb(trip_active & coast_stop & fault_contact, 1'b1);
		chb(minor_blink | minor_fault, 1'b0);
		fan_failure <= 1'b0;
		clr();
	endtask
	initial begin
		#(30000 * 100);
		mismatches++;
		report_and_stop();
	end
	initial begin
		{rst_b, run_cmd, fan_failure, ext_fault_reset, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, fault_in, mismatches, n_checks} = '0;
		s_axi_wstrb = 4'hF;
		cyc(6);
		rst_b <= 1'b1;
		run_cmd <= 1'b1;
		t_regs();
		t_elig();
		t_limit();
		t_fan();
		report_and_stop();
	end
endmodule
`default_nettype wire
